// ---- hw/cst_rate_tracker.v ----
// Coherent sampling rate tracker: line period estimate and chip-select timing
`timescale 1ns/1ps
`default_nettype none
`include "cst_consts.vh"

// Function
// [RULE_01] Detect line frequency from sample sign changes
// [RULE_02] Monitored channel is user selectable
// [RULE_03] Time ten crossings, five line cycles
// [RULE_04] Estimator separate, hands rate to acquisition
// [RULE_05] Coherent mode: 640 samples per line cycle
// [RULE_06] CS rate is frequency times 640 times 8
// [RULE_07] Coherent off: fixed 256 ksps rate
// [RULE_08] One common chip select to all converters
// [RULE_09] New period applies only at frame boundary; the code starts it at conversion 1 of the new frame
module cst_rate_tracker #(
  parameter DATA_W = 16,
  parameter SPAN_W = 24
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Sample stream from the converters
  input wire sampleValid,
  input wire [2:0] sampleChannel,
  input wire [DATA_W-1:0] sampleData,
  // User control
  input wire [2:0] monitorChannel,
  input wire coherentEnable,
  // Converter timing
  output reg csN,
  output reg [2:0] convIndex,
  output reg frameStart,
  // Status
  output reg [SPAN_W-1:0] measPeriodQ8,
  output reg measValid
);

  // ----------------------------------------------------------------
  // Derived constants
  // ----------------------------------------------------------------
  // Macros are 32 bits or wider; each is held at full width first
  // and then cut on purpose, so no constant silently drops bits
  localparam FB = `CST_FRAC_BITS;
  localparam INT_W = SPAN_W - FB;
  localparam [63:0] FIXED_FULL = `CST_FIXED_PERIOD_Q8;
  localparam [31:0] MIN_FULL = `CST_MIN_PERIOD_Q8;
  localparam [31:0] DIV_FULL = `CST_SPAN_DIVISOR;
  localparam [31:0] HIGH_FULL = `CST_CS_HIGH_CYC;
  localparam [31:0] CHAN_FULL = `CST_CHANNELS - 1;
  localparam [31:0] STEPS_FULL = SPAN_W;
  // Fixed rate: 390.625 clocks per conversion, fraction carried
  localparam [SPAN_W-1:0] FIXED_Q8 = FIXED_FULL[SPAN_W-1:0];
  // Floor against a noisy detector reporting an absurd line rate
  localparam [SPAN_W-1:0] MIN_Q8 = MIN_FULL[SPAN_W-1:0];
  // Divisor of 100 turns a five-cycle span straight into Q8
  localparam [7:0] SPAN_DIV = DIV_FULL[7:0];
  // Select high gap; the rest of each conversion is the low phase
  localparam [INT_W:0] CS_HIGH = HIGH_FULL[INT_W:0];
  // Last channel of the multiplexed frame
  localparam [2:0] LAST_CHAN = CHAN_FULL[2:0];
  // One quotient bit per clock, so a divide takes SPAN_W clocks
  localparam [4:0] DIV_STEPS = STEPS_FULL[4:0];

  // ----------------------------------------------------------------
  // Operating notes
  // ----------------------------------------------------------------
  // Samples arrive on this clock, so the stream has no synchroniser
  // Coherent mode without a lock keeps the fixed rate
  // Spans that saturate or finish while dividing are dropped
  // Divider latency is tiny next to one span, so little is lost
  // Rate changes wait for the end of conversion seven
  // First conversion of a new frame still runs at the old length
  // Fraction accumulator runs across frames for an exact mean rate
  // Limitation: a line faster than the floor keeps the last result

  // Divider states
  localparam DIV_IDLE = 1'b0;
  localparam DIV_BUSY = 1'b1;

  wire [SPAN_W-1:0] spanCycles;
  wire spanValid;

  // ----------------------------------------------------------------
  // Frequency estimator
  // ----------------------------------------------------------------
  // Estimation lives in its own unit; only a span word and its strobe cross over
  cst_zero_cross #(
    .DATA_W(DATA_W),
    .SPAN_W(SPAN_W)
  ) uZeroCross (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sampleValid(sampleValid),
    .sampleChannel(sampleChannel),
    .sampleData(sampleData),
    .monitorChannel(monitorChannel),
    .spanCycles(spanCycles),
    .spanValid(spanValid)
  ); // [RULE_04]

  // ----------------------------------------------------------------
  // Span to conversion period divider
  // ----------------------------------------------------------------
  reg divState;
  reg [4:0] divStep;
  reg [SPAN_W-1:0] divNum;
  reg [SPAN_W-1:0] divQuot;
  reg [7:0] divRem;
  wire [8:0] trialRem;
  wire [8:0] trialDiff;

  assign trialRem = {divRem, divNum[SPAN_W-1]};
  assign trialDiff = trialRem - {1'b0, SPAN_DIV};

  // Period Q8 = span / (5 * 640 * 8) * 256, one quotient bit per clock;
  // a span arriving while busy is dropped, the next one is 5 cycles away
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      divState <= DIV_IDLE;
      divStep <= 5'h0;
      divNum <= {SPAN_W{1'b0}};
      divQuot <= {SPAN_W{1'b0}};
      divRem <= 8'h00;
      measPeriodQ8 <= {SPAN_W{1'b0}};
      measValid <= 1'b0;
    end else begin
      case (divState)
        DIV_IDLE: begin
          if (spanValid) begin
            divNum <= spanCycles;
            divQuot <= {SPAN_W{1'b0}};
            divRem <= 8'h00;
            divStep <= 5'h0;
            divState <= DIV_BUSY;
          end
        end
        DIV_BUSY: begin
          divNum <= {divNum[SPAN_W-2:0], 1'b0};
          if (!trialDiff[8]) begin
            divRem <= trialDiff[7:0];
          end else begin
            divRem <= trialRem[7:0];
          end
          divQuot <= {divQuot[SPAN_W-2:0], ~trialDiff[8]}; // [RULE_06]
          divStep <= divStep + 1'b1;
          if (divStep == DIV_STEPS - 1'b1) begin
            divState <= DIV_IDLE;
            // Implausibly fast lines are ignored, last good value kept
            if ({divQuot[SPAN_W-2:0], ~trialDiff[8]} >= MIN_Q8) begin
              measPeriodQ8 <= {divQuot[SPAN_W-2:0], ~trialDiff[8]}; // [RULE_05]
              measValid <= 1'b1;
            end
          end
        end
        default: begin
          divState <= DIV_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Chip-select generator
  // ----------------------------------------------------------------
  reg [SPAN_W-1:0] framePeriodQ8;
  reg [FB-1:0] fracAcc;
  reg [INT_W:0] convLen;
  reg [INT_W:0] phase;
  wire [SPAN_W-1:0] wantPeriodQ8;
  wire [FB:0] fracSum;
  wire [INT_W:0] next_convLen;
  wire convEnd;
  wire frameEnd;

  // Without a lock the fixed rate stands even in coherent mode
  assign wantPeriodQ8 = (coherentEnable && measValid) ? measPeriodQ8 : FIXED_Q8; // [RULE_07]
  assign convEnd = (phase == convLen - 1'b1);
  assign frameEnd = convEnd && (convIndex == LAST_CHAN);
  // Fraction accumulates so the mean rate is exact, not just the integer part
  assign fracSum = {1'b0, fracAcc} + {1'b0, framePeriodQ8[FB-1:0]};
  assign next_convLen = {1'b0, framePeriodQ8[SPAN_W-1:FB]} + {{INT_W{1'b0}}, fracSum[FB]};

  // One shared select: high gap then low conversion, channel by channel
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      framePeriodQ8 <= FIXED_Q8;
      fracAcc <= {FB{1'b0}};
      convLen <= FIXED_Q8[SPAN_W-1:FB];
      phase <= {(INT_W+1){1'b0}};
      convIndex <= 3'h0;
      csN <= 1'b1;
      frameStart <= 1'b0;
    end else begin
      frameStart <= 1'b0;
      if (convEnd) begin
        phase <= {(INT_W+1){1'b0}};
        convLen <= next_convLen;
        fracAcc <= fracSum[FB-1:0];
        convIndex <= convIndex + 1'b1;
        csN <= 1'b1; // [RULE_08]
        if (frameEnd) begin
          // Period swaps only here so no select pulse is cut short
          framePeriodQ8 <= wantPeriodQ8; // [RULE_09]
          frameStart <= 1'b1;
        end
      end else begin
        phase <= phase + 1'b1;
        if (phase + 1'b1 >= CS_HIGH) begin
          csN <= 1'b0; // [RULE_08]
        end
      end
    end
  end

endmodule // cst_rate_tracker
`default_nettype wire

// ---- hw/cst_consts.vh ----
// Constants for the coherent sampling rate tracker
`ifndef CST_CONSTS_VH
`define CST_CONSTS_VH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define CST_CLK_HZ 100000000
`define CST_CLK_NS 10
`define CST_CS_HIGH_NS 40
`define CST_CS_HIGH_CYC ((`CST_CS_HIGH_NS + `CST_CLK_NS - 1) / `CST_CLK_NS)

// ----------------------------------------------------------------
// Sampling plan
// ----------------------------------------------------------------
`define CST_ZC_PER_SPAN 10
`define CST_SAMPLES_PER_CYCLE 640
`define CST_CHANNELS 8
`define CST_FRAC_BITS 8
`define CST_FIXED_SPS 256000

// Fixed conversion period, clock cycles with 8 fraction bits (390.625)
`define CST_FIXED_PERIOD_Q8 (64'd100000000 * 64'd256 / 64'd256000)
// Span cycles over this gives conversion period in Q8 (span/25600*256)
`define CST_SPAN_DIVISOR ((`CST_ZC_PER_SPAN / 2) * `CST_SAMPLES_PER_CYCLE * `CST_CHANNELS / 256)
// Shortest accepted measured period, Q8 (16 whole cycles)
`define CST_MIN_PERIOD_Q8 4096

`endif

// ---- hw/cst_zero_cross.v ----
// Zero-crossing span timer on one selectable sample channel
`timescale 1ns/1ps
`default_nettype none
`include "cst_consts.vh"

module cst_zero_cross #(
  parameter DATA_W = 16,
  parameter SPAN_W = 24
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Sample stream
  input wire sampleValid,
  input wire [2:0] sampleChannel,
  input wire [DATA_W-1:0] sampleData,
  input wire [2:0] monitorChannel,
  // Measured span
  output reg [SPAN_W-1:0] spanCycles,
  output reg spanValid
);

  // Held at full width, then cut on purpose to the counter width
  localparam [31:0] CROSS_FULL = `CST_ZC_PER_SPAN - 1;
  localparam [3:0] LAST_CROSS = CROSS_FULL[3:0];

  reg [2:0] lastChannel;
  reg prevSign;
  reg havePrev;
  reg armed;
  reg [3:0] crossCount;
  reg [SPAN_W-1:0] spanCount;
  reg overflow;
  wire hit;
  wire crossing;
  wire chanChange;

  // Only the user-chosen channel feeds the detector
  assign hit = sampleValid && (sampleChannel == monitorChannel); // [RULE_02]
  // Sign change between successive samples; zero counts as positive
  assign crossing = hit && havePrev && (sampleData[DATA_W-1] != prevSign); // [RULE_01]
  assign chanChange = (lastChannel != monitorChannel);

  // ----------------------------------------------------------------
  // Span measurement over ten crossings
  // ----------------------------------------------------------------
  // A channel change restarts everything so spans never mix channels
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lastChannel <= 3'h0;
      prevSign <= 1'b0;
      havePrev <= 1'b0;
      armed <= 1'b0;
      crossCount <= 4'h0;
      spanCount <= {SPAN_W{1'b0}};
      overflow <= 1'b0;
      spanCycles <= {SPAN_W{1'b0}};
      spanValid <= 1'b0;
    end else begin
      lastChannel <= monitorChannel;
      spanValid <= 1'b0;
      if (chanChange) begin
        havePrev <= 1'b0;
        armed <= 1'b0;
      end else begin
        if (hit) begin
          prevSign <= sampleData[DATA_W-1];
          havePrev <= 1'b1;
        end
        // Saturate: a stalled input must not wrap into a short span
        if (armed) begin
          if (&spanCount) begin
            overflow <= 1'b1;
          end else begin
            spanCount <= spanCount + 1'b1;
          end
        end
        if (crossing) begin
          if (!armed || crossCount == LAST_CROSS) begin
            armed <= 1'b1;
            crossCount <= 4'h0;
            spanCount <= {SPAN_W{1'b0}};
            overflow <= 1'b0;
            // Tenth crossing closes five line cycles
            if (armed && !overflow) begin
              spanCycles <= spanCount + 1'b1; // [RULE_03]
              spanValid <= 1'b1;
            end
          end else begin
            crossCount <= crossCount + 1'b1;
          end
        end
      end
    end
  end

endmodule // cst_zero_cross
`default_nettype wire

// ---- verification/cst_rate_chk.sv ----
// Checker for chip-select timing and measurement status
`timescale 1ns/1ps
`default_nettype none
module cst_rate_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Observed outputs
  input wire logic csN,
  input wire logic [2:0] convIndex,
  input wire logic frameStart,
  input wire logic [23:0] measPeriodQ8,
  input wire logic measValid
);
  // ----
  // Properties
  // ----
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Select high for four cycles, then low
  sequence csHighPhase;
    csN [*4] ##1 !csN;
  endsequence
  cs_high_a: assert property ($changed(convIndex) |-> csHighPhase)
    else $error("select high phase wrong");
  cs_rise_a: assert property ($rose(csN) |-> $changed(convIndex))
    else $error("select rose inside a conversion");
  idx_step_a: assert property ($changed(convIndex) |-> convIndex == $past(convIndex) + 3'h1)
    else $error("channel index skipped");
  frame_wrap_a: assert property (frameStart |-> convIndex == 3'h0 && $past(convIndex) == 3'h7)
    else $error("frame start off boundary");
  frame_pulse_a: assert property (frameStart |=> !frameStart)
    else $error("frame start too long");
  low_min_a: assert property ($fell(csN) |-> !csN [*8])
    else $error("conversion shorter than minimum");
  valid_hold_a: assert property (measValid |=> measValid)
    else $error("measurement flag dropped");
  period_min_a: assert property (measValid |-> measPeriodQ8 >= 24'h1000)
    else $error("period below floor");
endmodule // cst_rate_chk
bind cst_rate_tracker cst_rate_chk chk (.ref_clk(ref_clk), .rst_n(rst_n), .csN(csN),
  .convIndex(convIndex), .frameStart(frameStart), .measPeriodQ8(measPeriodQ8),
  .measValid(measValid));
`default_nettype wire

// ---- verification/cst_adc_model.sv ----
// Converter group model: square line wave on channel 5, others flip each frame
`timescale 1ns/1ps
`default_nettype none
module cst_adc_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Wave half period, cycles
  input wire logic [31:0] halfPeriod,
  // Sample stream
  output logic sampleValid,
  output logic [2:0] sampleChannel,
  output logic [15:0] sampleData
);
  logic [31:0] phase;
  logic [31:0] lastHalf;
  logic waveNeg;
  logic busyNeg;
  // One word a cycle; phase restarts on a new half period so spans stay exact
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 32'h0;
      lastHalf <= 32'h0;
      waveNeg <= 1'b0;
      busyNeg <= 1'b0;
      sampleValid <= 1'b0;
      sampleChannel <= 3'h0;
      sampleData <= 16'h0;
    end else begin
      lastHalf <= halfPeriod;
      phase <= (halfPeriod != lastHalf || phase == halfPeriod - 32'h1) ? 32'h0 : phase + 32'h1;
      if (halfPeriod == lastHalf && phase == halfPeriod - 32'h1) waveNeg <= ~waveNeg;
      if (sampleChannel == 3'h7) busyNeg <= ~busyNeg;
      sampleValid <= 1'b1;
      sampleChannel <= sampleChannel + 3'h1;
      sampleData <= ((sampleChannel + 3'h1) == 3'h5 ? waveNeg : busyNeg) ? 16'hC000 : 16'h4000;
    end
  end
endmodule // cst_adc_model
`default_nettype wire

// ---- verification/cst_rate_tracker_test.sv ----
// Testbench for the coherent sampling rate tracker
`timescale 1ns/1ps
`default_nettype none
module cst_rate_tracker_test;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic coherentEnable = 1'b1;
  logic [2:0] monitorChannel = 3'h0;
  logic [31:0] halfPeriod = 32'h0000_0320;
  logic sampleValid, csN, frameStart, measValid;
  logic [2:0] sampleChannel, convIndex;
  logic [15:0] sampleData;
  logic [23:0] measPeriodQ8, len;
  int n_mismatch = 0;
  int n_tests = 0;
  // ----
  // Clock, model and design
  // ----
  initial forever #5 ref_clk = ~ref_clk;
  cst_adc_model adc (.ref_clk(ref_clk), .rst_n(rst_n), .halfPeriod(halfPeriod),
    .sampleValid(sampleValid), .sampleChannel(sampleChannel), .sampleData(sampleData));
  cst_rate_tracker dut (.ref_clk(ref_clk), .rst_n(rst_n), .sampleValid(sampleValid),
    .sampleChannel(sampleChannel), .sampleData(sampleData), .monitorChannel(monitorChannel),
    .coherentEnable(coherentEnable), .csN(csN), .convIndex(convIndex),
    .frameStart(frameStart), .measPeriodQ8(measPeriodQ8), .measValid(measValid));
  // ----
  // Shared tasks
  // ----
  task check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task test_done;
    if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Cycles between frame starts; sampled 1 ns after the edge to dodge races
  task frame_len(output logic [23:0] n);
    int i;
    n = 24'h0;
    for (i = 0; i < 4000 && frameStart !== 1'b1; i++) begin
      @(posedge ref_clk) #1;
    end
    for (i = 0; i < 4000; i++) begin
      @(posedge ref_clk) #1;
      n = n + 24'h1;
      if (frameStart === 1'b1) break;
    end
  endtask
  // ----
  // Scenarios
  // ----
  // Coherent asked but nothing measured yet: fixed 3125-cycle frames
  task t_fixed;
    frame_len(len);
    frame_len(len);
    check("fixed frame", len, 24'h0C35);
  endtask
  // Crossings too close together give a period under the floor
  task t_refuse;
    @(posedge ref_clk) monitorChannel <= 3'h5;
    repeat (9600) @(posedge ref_clk);
    #1;
    check("valid flag", measValid, 24'h0);
    check("period", measPeriodQ8, 24'h0);
  endtask
  // Half period 40960 gives span 409600, 16-cycle conversions, 128-cycle frames
  task t_track;
    int i;
    @(posedge ref_clk) begin
      halfPeriod <= 32'h0000_A000;
      monitorChannel <= 3'h6;
    end
    @(posedge ref_clk) monitorChannel <= 3'h5;
    for (i = 0; i < 500000 && measValid !== 1'b1; i++) begin
      @(posedge ref_clk) #1;
    end
    check("period", measPeriodQ8, 24'h1000);
    repeat (3) frame_len(len);
    check("coherent frame", len, 24'h0080);
  endtask
  // Leaving coherent mode returns to the fixed rate despite a valid result
  task t_off;
    @(posedge ref_clk) coherentEnable <= 1'b0;
    repeat (3) frame_len(len);
    check("fixed frame", len, 24'h0C35);
  endtask
  // ----
  // Main sequence and watchdog
  // ----
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_fixed;
    t_refuse;
    t_track;
    t_off;
    test_done;
  end
  // Whole run is near 480k cycles; a hang past 700k ends it
  initial begin
    #7000000;
    n_mismatch++;
    test_done;
  end
endmodule // cst_rate_tracker_test
`default_nettype wire
